//--- core/atp_pkg.sv
// Package: register map, field layout and reset values of the thermal bank
// How it works
// - Channel enable bit 7 turns input current measurement on.
// - Bit 6 turns system rail voltage measurement on.
// - Bit 5 turns charge current measurement on.
// - Bit 4 turns input voltage measurement on.
// - Bit 3 turns battery voltage measurement on.
// - Bit 2 turns thermistor measurement on.
// - Bit 1 turns aux input measurement on; bit 0 reserved.
// - Channel enable register resets to zero.
// - Bits 6:4 of derating lower battery voltage 50 mV per step.
// - Bits 2:0 scale charge current to (8 - code) eighths.
// - Derating register resets to voltage code 011, current code 100.
// - Threshold registers hold 8-bit codes, LSB 4.688 mV.
// - Cold threshold resets to 0x7C.
// - Cool threshold resets to 0x6D.
// - Warm threshold resets to 0x38.
// - Hot threshold resets to 0x27.
package atp_pkg;
	localparam logic [7:0] ATP_OFS_CHAN_EN = 8'h58;
	localparam logic [7:0] ATP_OFS_DERATE = 8'h61;
	localparam logic [7:0] ATP_OFS_COLD = 8'h62;
	localparam logic [7:0] ATP_OFS_COOL = 8'h63;
	localparam logic [7:0] ATP_OFS_WARM = 8'h64;
	localparam logic [7:0] ATP_OFS_HOT = 8'h65;
	localparam logic [7:0] ATP_RST_CHAN_EN = 8'h00;
	localparam logic [7:0] ATP_RST_DERATE = 8'h34;
	localparam logic [7:0] ATP_RST_COLD = 8'h7c;
	localparam logic [7:0] ATP_RST_COOL = 8'h6d;
	localparam logic [7:0] ATP_RST_WARM = 8'h38;
	localparam logic [7:0] ATP_RST_HOT = 8'h27;
	localparam int ATP_BIT_IIN = 7;
	localparam int ATP_BIT_RAIL = 6;
	localparam int ATP_BIT_FAST_CHARGE_CURRENT_SETTING = 5;
	localparam int ATP_BIT_VIN = 4;
	localparam int ATP_BIT_VBAT = 3;
	localparam int ATP_BIT_THERM = 2;
	localparam int ATP_BIT_AUX = 1;
	localparam int ATP_VDER_LSB = 4;
	localparam int ATP_IDER_LSB = 0;
	localparam int ATP_VDER_STEP_MV = 50;
	localparam int ATP_NUM_REGS = 6;

	// Per-channel measurement enables
	typedef struct packed {
		logic input_current_meas_enable;
		logic system_rail_meas_enable;
		logic charge_current_meas_enable;
		logic input_voltage_meas_enable;
		logic battery_voltage_meas_enable;
		logic thermistor_meas_enable;
		logic aux_input_meas_enable;
	} atp_chan_en_t;

	// Thermal profile handed to the charger
	typedef struct packed {
		logic [2:0] warm_voltage_derating;
		logic [2:0] thermal_current_derating;
		logic [8:0] vreg_reduction_mv;
		logic [3:0] current_eighths;
		logic [7:0] cold_threshold_code;
		logic [7:0] cool_threshold_code;
		logic [7:0] warm_threshold_code;
		logic [7:0] hot_threshold_code;
	} atp_profile_t;

	// Register access strobe
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} atp_req_t;
endpackage

//--- core/atp_reg8.sv
// Single 8-bit read/write register with reset value
`timescale 1ns/100ps
module atp_reg8
	import atp_pkg::*;
#(
	parameter logic [7:0] RST_VAL = 8'h00
) (
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// Write port
	input wire logic wr_in,
	input wire logic [7:0] wdata_in,
	// Stored value
	output logic [7:0] q_out
);
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			q_out <= RST_VAL;
		end else if (ce_in && wr_in) begin
			q_out <= wdata_in;
		end
	end
endmodule

//--- core/atp_thermal_regs.sv
// Channel enable and thermal charging profile register bank
`timescale 1ns/100ps
module atp_thermal_regs
	import atp_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	// Register access from the serial interface decoder
	input wire atp_req_t req_in,
	output logic [7:0] rdata_out,
	output logic rvalid_out,
	output logic addr_hit_out,
	// Configuration to converter and charger
	output atp_chan_en_t chan_en_out,
	output atp_profile_t profile_out
);
	logic [ATP_NUM_REGS-1:0] hit;
	logic [7:0] q [ATP_NUM_REGS];
	logic [7:0] rdata_next;
	logic hit_any;

	localparam logic [7:0] OFS [ATP_NUM_REGS] = '{ATP_OFS_CHAN_EN,
		ATP_OFS_DERATE, ATP_OFS_COLD, ATP_OFS_COOL, ATP_OFS_WARM,
		ATP_OFS_HOT};
	localparam logic [7:0] RSTV [ATP_NUM_REGS] = '{ATP_RST_CHAN_EN,
		ATP_RST_DERATE, ATP_RST_COLD, ATP_RST_COOL, ATP_RST_WARM,
		ATP_RST_HOT};

	// One storage register per offset; reset values set
	// and
	genvar gi;
	generate
		for (gi = 0; gi < ATP_NUM_REGS; gi++) begin : g_reg
			assign hit[gi] = (req_in.addr == OFS[gi]);
			atp_reg8 #(
				.RST_VAL(RSTV[gi])
			) u_reg (
				.clk_sys_in(clk_sys_in),
				.sys_rst_in(sys_rst_in),
				.ce_in(ce_in),
				.wr_in(req_in.wr && hit[gi]),
				.wdata_in(req_in.wdata),
				.q_out(q[gi])
			);
		end
	endgenerate

	assign hit_any = |hit;
	assign addr_hit_out = hit_any;

	// Reserved bits are stored too, so they read back as written
	always_comb begin
		rdata_next = 8'h00;
		for (int i = 0; i < ATP_NUM_REGS; i++) begin
			if (hit[i]) begin
				rdata_next = q[i];
			end
		end
	end

	// Read data registered; unmapped offsets read as zero
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			rdata_out <= 8'h00;
			rvalid_out <= 1'b0;
		end else if (ce_in) begin
			rvalid_out <= req_in.rd;
			if (req_in.rd) begin
				rdata_out <= rdata_next;
			end
		end
	end

	// Channel enables; bit 0 stays out of the converter
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			chan_en_out <= '0;
		end else if (ce_in) begin
			chan_en_out.input_current_meas_enable <= q[0][ATP_BIT_IIN];
			chan_en_out.system_rail_meas_enable <= q[0][ATP_BIT_RAIL];
			chan_en_out.charge_current_meas_enable <= q[0][ATP_BIT_FAST_CHARGE_CURRENT_SETTING];
			chan_en_out.input_voltage_meas_enable <= q[0][ATP_BIT_VIN];
			chan_en_out.battery_voltage_meas_enable <= q[0][ATP_BIT_VBAT];
			chan_en_out.thermistor_meas_enable <= q[0][ATP_BIT_THERM];
			chan_en_out.aux_input_meas_enable <= q[0][ATP_BIT_AUX];
		end
	end

	// Derived derating values; reserved bits 7 and 3 ignored
	logic [2:0] vcode;
	logic [2:0] icode;
	assign vcode = q[1][ATP_VDER_LSB +: 3];
	assign icode = q[1][ATP_IDER_LSB +: 3];

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			profile_out.warm_voltage_derating <= ATP_RST_DERATE[ATP_VDER_LSB +: 3];
			profile_out.thermal_current_derating <=
				ATP_RST_DERATE[ATP_IDER_LSB +: 3];
			profile_out.vreg_reduction_mv <= 9'h096;
			profile_out.current_eighths <= 4'h4;
			profile_out.cold_threshold_code <= ATP_RST_COLD;
			profile_out.cool_threshold_code <= ATP_RST_COOL;
			profile_out.warm_threshold_code <= ATP_RST_WARM;
			profile_out.hot_threshold_code <= ATP_RST_HOT;
		end else if (ce_in) begin
			profile_out.warm_voltage_derating <= vcode;
			profile_out.thermal_current_derating <= icode;
			profile_out.vreg_reduction_mv <=
				9'(int'(vcode) * ATP_VDER_STEP_MV);
			profile_out.current_eighths <= 4'h8 - {1'b0, icode};
			profile_out.cold_threshold_code <= q[2];
			profile_out.cool_threshold_code <= q[3];
			profile_out.warm_threshold_code <= q[4];
			profile_out.hot_threshold_code <= q[5];
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);

	a_chan_rst: assert property ($fell(sys_rst_in) |-> q[0] == 8'h00)
		else $error("channel enable reset value wrong");
	a_derate_rst: assert property ($fell(sys_rst_in) |-> q[1] == 8'h34)
		else $error("derating reset value wrong");
	a_cold_rst: assert property ($fell(sys_rst_in) |-> q[2] == 8'h7c)
		else $error("cold threshold reset value wrong");
	a_cool_rst: assert property ($fell(sys_rst_in) |-> q[3] == 8'h6d)
		else $error("cool threshold reset value wrong");
	a_warm_rst: assert property ($fell(sys_rst_in) |-> q[4] == 8'h38)
		else $error("warm threshold reset value wrong");
	a_hot_rst: assert property ($fell(sys_rst_in) |-> q[5] == 8'h27)
		else $error("hot threshold reset value wrong");
	a_write_readback: assert property (ce_in && req_in.wr && hit_any &&
		!$past(sys_rst_in) ##1 ce_in && req_in.rd && !req_in.wr &&
		req_in.addr == $past(req_in.addr) |=> rdata_out == $past(req_in.wdata, 2))
		else $error("read back differs from write");
	a_iin_enable: assert property (ce_in && req_in.wr &&
		req_in.addr == ATP_OFS_CHAN_EN ##1 ce_in |=>
		chan_en_out.input_current_meas_enable == $past(req_in.wdata[7], 2))
		else $error("input current enable not following bit 7");
	a_aux_enable: assert property (ce_in && req_in.wr &&
		req_in.addr == ATP_OFS_CHAN_EN ##1 ce_in |=>
		chan_en_out.aux_input_meas_enable == $past(req_in.wdata[1], 2))
		else $error("aux enable not following bit 1");
	a_vreg_step: assert property (profile_out.vreg_reduction_mv ==
		9'(int'(profile_out.warm_voltage_derating) * 50))
		else $error("voltage reduction not 50 mV per step");
	a_curr_scale: assert property (profile_out.current_eighths +
		4'(profile_out.thermal_current_derating) == 4'h8)
		else $error("current scale not eight minus code");
	a_unmapped_zero: assert property (ce_in && req_in.rd && !hit_any |=>
		rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_rail_enable: assert property (ce_in && req_in.wr &&
		req_in.addr == ATP_OFS_CHAN_EN ##1 ce_in |=>
		chan_en_out.system_rail_meas_enable == $past(req_in.wdata[6], 2))
		else $error("system rail enable not following bit 6");
	a_fast_charge_current_setting_enable: assert property (ce_in && req_in.wr &&
		req_in.addr == ATP_OFS_CHAN_EN ##1 ce_in |=>
		chan_en_out.charge_current_meas_enable == $past(req_in.wdata[5], 2))
		else $error("charge current enable not following bit 5");
	a_vin_enable: assert property (ce_in && req_in.wr &&
		req_in.addr == ATP_OFS_CHAN_EN ##1 ce_in |=>
		chan_en_out.input_voltage_meas_enable == $past(req_in.wdata[4], 2))
		else $error("input voltage enable not following bit 4");
	a_vbat_enable: assert property (ce_in && req_in.wr &&
		req_in.addr == ATP_OFS_CHAN_EN ##1 ce_in |=>
		chan_en_out.battery_voltage_meas_enable == $past(req_in.wdata[3], 2))
		else $error("battery voltage enable not following bit 3");
	a_therm_enable: assert property (ce_in && req_in.wr &&
		req_in.addr == ATP_OFS_CHAN_EN ##1 ce_in |=>
		chan_en_out.thermistor_meas_enable == $past(req_in.wdata[2], 2))
		else $error("thermistor enable not following bit 2");
	// Thresholds pass through untouched once the enable has let them in
	a_cold_follow: assert property (ce_in |=>
		profile_out.cold_threshold_code == $past(q[2]))
		else $error("cold threshold output not following register");
	a_hot_follow: assert property (ce_in |=>
		profile_out.hot_threshold_code == $past(q[5]))
		else $error("hot threshold output not following register");
	// A low enable must hold the channel enable and profile outputs, not only the registers
	a_freeze_outputs: assert property (!ce_in |=>
		$stable(chan_en_out) && $stable(profile_out))
		else $error("outputs moved while enable low");

	c_chan_write: cover property (ce_in && req_in.wr &&
		req_in.addr == ATP_OFS_CHAN_EN);
	c_derate_max: cover property (profile_out.current_eighths == 4'h1);
	c_thresh_read: cover property (ce_in && req_in.rd &&
		req_in.addr == ATP_OFS_HOT);
	c_frozen_write: cover property (!ce_in && req_in.wr && hit_any);
endmodule

//--- testbench/atp_host_model.sv
// Host controller model issuing register accesses
`timescale 1ns/100ps
module atp_host_model
	import atp_pkg::*;
(
	// Clock
	input wire logic clk_sys_in,
	// Read answer
	input wire logic [7:0] rdata_in,
	input wire logic rvalid_in,
	// Access strobe
	output atp_req_t req_out
);
	initial req_out = '0;
	function automatic logic [7:0] rsv_mask(input logic [7:0] a);
		case (a)
			ATP_OFS_CHAN_EN: return 8'hfe;
			ATP_OFS_DERATE: return 8'h77;
			default: return 8'hff;
		endcase
	endfunction
	// Held a full cycle, released after the taking edge
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic v);
		@(posedge clk_sys_in);
		#1;
		req_out = '{wr: w, rd: !w, addr: a, wdata: d & rsv_mask(a)};
		@(posedge clk_sys_in);
		#1;
		req_out = '0;
		q = rdata_in;
		v = rvalid_in;
	endtask
endmodule

//--- testbench/atp_thermal_regs_tb_top.sv
// Self-checking bench for the thermal register bank
`timescale 1ns/100ps
module atp_thermal_regs_tb_top
	import atp_pkg::*;
	;
	localparam logic [7:0] OFS [6] = '{ATP_OFS_CHAN_EN, ATP_OFS_DERATE,
		ATP_OFS_COLD, ATP_OFS_COOL, ATP_OFS_WARM, ATP_OFS_HOT};
	localparam logic [7:0] RST [6] = '{ATP_RST_CHAN_EN, ATP_RST_DERATE,
		ATP_RST_COLD, ATP_RST_COOL, ATP_RST_WARM, ATP_RST_HOT};
	logic clk_sys_in = 0;
	logic sys_rst_in = 1;
	logic ce_in = 1;
	atp_req_t req;
	logic [7:0] rdata, q;
	logic rvalid, v;
	atp_chan_en_t chan_en;
	atp_profile_t profile;
	logic [7:0] mdl [6];
	logic [31:0] seed = 8379;
	int fails = 0;
	int total_checks = 0;
	always #2 clk_sys_in = !clk_sys_in;
	atp_thermal_regs DUT (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
		.ce_in(ce_in), .req_in(req), .rdata_out(rdata), .rvalid_out(rvalid),
		.addr_hit_out(), .chan_en_out(chan_en), .profile_out(profile));
	atp_host_model HOST (.clk_sys_in(clk_sys_in), .rdata_in(rdata),
		.rvalid_in(rvalid), .req_out(req));
	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	function automatic logic [57:0] cfg_exp();
		logic [7:0] t;
		t = mdl[1];
		return {mdl[0][7:1], t[6:4], t[2:0], 9'(t[6:4] * ATP_VDER_STEP_MV),
			4'(4'h8 - t[2:0]), mdl[2], mdl[3], mdl[4], mdl[5]};
	endfunction
	task automatic chk_rd(string n, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_cfg(logic [57:0] e, logic [57:0] g);
		total_checks++;
		if (g !== e) begin
			fails++;
			$display("unexpected config exp %h got %h", e, g);
		end
	endtask
	task automatic rd(input int i);
		HOST.xfer(0, OFS[i], 8'h00, q, v);
		chk_rd("rvalid", 8'h01, {7'h00, v});
		chk_rd("rdata", mdl[i], q);
	endtask
	task automatic wr(input int i, input logic [7:0] d);
		HOST.xfer(1, OFS[i], d, q, v);
		mdl[i] = d & HOST.rsv_mask(OFS[i]);
		// Outputs follow one edge after the register
		@(posedge clk_sys_in);
		#1;
		chk_cfg(cfg_exp(), {chan_en, profile});
	endtask
	task automatic chk_all();
		for (int i = 0; i < 6; i++) rd(i);
		chk_cfg(cfg_exp(), {chan_en, profile});
	endtask
	task automatic do_reset();
		sys_rst_in = 1;
		repeat (4) @(posedge clk_sys_in);
		#1;
		sys_rst_in = 0;
		for (int i = 0; i < 6; i++) mdl[i] = RST[i];
	endtask
	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		#20000;
		fails++;
		test_done();
	end
	initial begin
		do_reset();
		chk_all();
		for (int b = 1; b < 8; b++) wr(0, 8'(1 << b));
		for (int k = 0; k < 8; k++) wr(1, {1'b0, 3'(k), 1'b0, 3'(7 - k)});
		repeat (24) begin
			seed = xs(seed);
			wr(int'(seed % 6), seed[15:8]);
			rd(int'(seed % 6));
		end
		HOST.xfer(0, 8'h66, 8'h00, q, v);
		chk_rd("unmapped", 8'h00, q);
		HOST.xfer(1, 8'h60, 8'hff, q, v);
		// Frozen clock enable must drop the write
		@(posedge clk_sys_in);
		#1;
		ce_in = 0;
		HOST.xfer(1, OFS[5], ~mdl[5], q, v);
		ce_in = 1;
		chk_all();
		@(posedge clk_sys_in);
		#1;
		do_reset();
		chk_all();
		test_done();
	end
endmodule
